// file: src/sdram_ctl_defines.svh
// Timing counts, pin encodings and field positions of the SDRAM command controller
`ifndef SDRAM_CTL_DEFINES_SVH
`define SDRAM_CTL_DEFINES_SVH

// Clock rate in MHz
`define CLK_MHZ 40
// Fixed periods in ns, as figures of the controller's own choosing
`define PRECHARGE_NS 20
`define ROW_CYCLE_NS 70
`define ROW_ACTIVE_NS 45
`define MODE_LOAD_NS 20
// Least times round up to whole cycles, never below one
`define NS2CYC(ns) ((((ns) * `CLK_MHZ) + 999) / 1000 < 1 ? 1 : (((ns) * `CLK_MHZ) + 999) / 1000)
`define PRECHARGE_CYC `NS2CYC(`PRECHARGE_NS)
`define ROW_CYCLE_CYC `NS2CYC(`ROW_CYCLE_NS)
`define ROW_ACTIVE_CYC `NS2CYC(`ROW_ACTIVE_NS)
`define MODE_LOAD_CYC `NS2CYC(`MODE_LOAD_NS)
// Least no-op clocks after leaving self refresh
`define EXIT_NOP_CYC 2
// Refresh budget: 4096 commands per 64 ms window
`define REFRESH_COUNT 4096
`define REFRESH_WINDOW_US 64000
`define REFRESH_INTERVAL_CYC ((`REFRESH_WINDOW_US * `CLK_MHZ) / `REFRESH_COUNT)
// Address field positions
`define PRECHARGE_SELECT_POS 10
`define COLUMN_MSB 7
`define ROW_MSB 10
// Command codes as {rowStrobe, colStrobe, writeStrobe}, active low pins
`define CODE_NOP 3'h7
`define CODE_ACTIVATE 3'h3
`define CODE_READ 3'h5
`define CODE_WRITE 3'h4
`define CODE_TERMINATE 3'h6
`define CODE_PRECHARGE 3'h2
`define CODE_REFRESH 3'h1
`define CODE_MODE_LOAD 3'h0

`endif

// file: src/sdram_ctl_pkg.sv
// Types shared by the SDRAM command controller
package sdram_ctl_pkg;
    // User orders
    typedef enum logic [3:0] {
        OP_ACTIVATE,
        OP_READ,
        OP_WRITE,
        OP_PRECHARGE,
        OP_PRECHARGE_ALL,
        OP_TERMINATE,
        OP_REFRESH,
        OP_MODE_LOAD,
        OP_SELF_REFRESH,
        OP_POWER_DOWN,
        OP_SUSPEND
    } op_t;
endpackage : sdram_ctl_pkg

// file: src/wait_timer_if.sv
// Interface between controller and its wait timer
`timescale 1ns/10ps
interface wait_timer_if;
    logic load;         // Start a wait
    logic [15:0] count; // Cycles to wait
    logic busy;         // Wait still running
    modport ctl (output load, output count, input busy);
    modport tmr (input load, input count, output busy);
endinterface : wait_timer_if

// file: src/wait_timer.sv
// Down counter that holds off commands for a loaded number of cycles
`timescale 1ns/10ps
module wait_timer (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Controller side
    wait_timer_if.tmr tmr
);
    logic [15:0] left_r;
    logic [15:0] left_nxt;

    // Next count
    always_comb
    begin
        left_nxt = left_r;
        if (tmr.load)
        begin
            left_nxt = tmr.count;
        end
        else if (left_r != 16'h0)
        begin
            left_nxt = left_r - 16'h1;
        end
    end

    // Register
    always_ff @(posedge core_clk)
    begin
        if (srst)
            left_r <= 16'h0;
        else
            left_r <= left_nxt;
    end

    assign tmr.busy = (left_r > 16'h1);
endmodule : wait_timer

// file: src/sdram_ctl.sv
// SDRAM command controller: issues commands and clock-enable moves on the device pins
`timescale 1ns/10ps
`include "sdram_ctl_defines.svh"

module sdram_ctl #(
    parameter int PRECHARGE_CYC = `PRECHARGE_CYC,
    parameter int ROW_CYCLE_CYC = `ROW_CYCLE_CYC,
    parameter int ROW_ACTIVE_CYC = `ROW_ACTIVE_CYC,
    parameter int MODE_LOAD_CYC = `MODE_LOAD_CYC,
    parameter int REFRESH_INTERVAL_CYC = `REFRESH_INTERVAL_CYC
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // User orders
    input wire logic opValid,
    input wire sdram_ctl_pkg::op_t opCode,
    input wire logic [1:0] opBank,
    input wire logic [10:0] opAddr,
    input wire logic opAutoPre,
    input wire logic [3:0] opMask,
    input wire logic opWake,
    output logic opReady,
    output logic refreshDue,
    // Device pins
    output logic clkEnable,
    output logic chipSelect_n,
    output logic rowStrobe_n,
    output logic colStrobe_n,
    output logic writeStrobe_n,
    output logic [1:0] bank_select,
    output logic [10:0] addr,
    output logic [3:0] byteMask
);
    import sdram_ctl_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [2:0] {ST_RUN, ST_SELF, ST_POWER, ST_SUSPEND, ST_EXIT_NOP} state_t;

    state_t state_r, state_nxt;
    logic cke_r, cke_nxt;               // Clock enable pin
    logic cs_n_r, cs_n_nxt;             // Chip select pin
    logic [2:0] code_r, code_nxt;       // Strobe code
    logic [1:0] bank_r, bank_nxt;       // Bank pins
    logic [10:0] addr_r, addr_nxt;      // Address pins
    logic [3:0] mask_r, mask_nxt;       // Byte mask pins
    logic [15:0] selfCnt_r, selfCnt_nxt; // Self refresh dwell
    logic [1:0] nopCnt_r, nopCnt_nxt;   // Exit no-op count
    logic [15:0] refCnt_r, refCnt_nxt;  // Refresh interval
    logic refDue_r, refDue_nxt;         // Refresh owed
    logic inBurst_r, inBurst_nxt;       // Burst possibly in flight
    logic ready_r, ready_nxt;           // Order accepted next

    wait_timer_if tw ();

    wait_timer u_wait (
        .core_clk (core_clk),
        .srst (srst),
        .tmr (tw.tmr)
    );

    // ----------------------------------------
    // Command sequencing
    // ----------------------------------------
    // Next pin values, one order at a time
    always_comb
    begin
        state_nxt = state_r;
        cke_nxt = cke_r;
        cs_n_nxt = 1'b1;
        code_nxt = `CODE_NOP;
        bank_nxt = bank_r;
        addr_nxt = addr_r;
        mask_nxt = 4'hf;
        selfCnt_nxt = (selfCnt_r != 16'h0) ? selfCnt_r - 16'h1 : 16'h0;
        nopCnt_nxt = nopCnt_r;
        inBurst_nxt = inBurst_r;
        tw.load = 1'b0;
        tw.count = 16'h0;
        refCnt_nxt = refCnt_r + 16'h1;
        refDue_nxt = refDue_r;
        case (state_r)
            ST_RUN:
            begin
                if (opValid && ready_r)
                begin
                    cs_n_nxt = 1'b0;
                    bank_nxt = opBank;
                    case (opCode)
                        OP_ACTIVATE:
                        begin
                            code_nxt = `CODE_ACTIVATE;
                            addr_nxt = opAddr;
                            inBurst_nxt = 1'b0;
                        end
                        OP_READ, OP_WRITE:
                        begin
                            code_nxt = (opCode == OP_WRITE) ? `CODE_WRITE : `CODE_READ;
                            addr_nxt = 11'h0;
                            addr_nxt[`COLUMN_MSB:0] = opAddr[`COLUMN_MSB:0];
                            addr_nxt[`PRECHARGE_SELECT_POS] = opAutoPre;
                            mask_nxt = opMask;
                            inBurst_nxt = 1'b1;
                        end
                        OP_PRECHARGE, OP_PRECHARGE_ALL:
                        begin
                            code_nxt = `CODE_PRECHARGE;
                            addr_nxt[`PRECHARGE_SELECT_POS] = (opCode == OP_PRECHARGE_ALL);
                            inBurst_nxt = 1'b0;
                            tw.load = 1'b1;
                            tw.count = 16'(PRECHARGE_CYC);
                        end
                        OP_TERMINATE:
                        begin
                            code_nxt = `CODE_TERMINATE;
                            inBurst_nxt = 1'b0;
                        end
                        OP_REFRESH:
                        begin
                            code_nxt = `CODE_REFRESH;
                            refDue_nxt = 1'b0;
                            tw.load = 1'b1;
                            tw.count = 16'(ROW_CYCLE_CYC);
                        end
                        OP_MODE_LOAD:
                        begin
                            code_nxt = `CODE_MODE_LOAD;
                            addr_nxt = opAddr;
                            tw.load = 1'b1;
                            tw.count = 16'(MODE_LOAD_CYC);
                        end
                        OP_SELF_REFRESH:
                        begin
                            code_nxt = `CODE_REFRESH;
                            cke_nxt = 1'b0;
                            refDue_nxt = 1'b0;
                            selfCnt_nxt = 16'(ROW_ACTIVE_CYC);
                            state_nxt = ST_SELF;
                        end
                        OP_POWER_DOWN:
                        begin
                            code_nxt = `CODE_NOP;
                            cke_nxt = 1'b0;
                            state_nxt = ST_POWER;
                        end
                        OP_SUSPEND:
                        begin
                            // Suspend only while a burst may be running
                            cs_n_nxt = 1'b1;
                            if (inBurst_r)
                            begin
                                cke_nxt = 1'b0;
                                state_nxt = ST_SUSPEND;
                            end
                        end
                        default:
                        begin
                            cs_n_nxt = 1'b1;
                        end
                    endcase
                end
            end
            ST_SELF:
            begin
                if (opWake && selfCnt_r == 16'h0)
                begin
                    cke_nxt = 1'b1;
                    nopCnt_nxt = 2'(`EXIT_NOP_CYC);
                    tw.load = 1'b1;
                    tw.count = 16'(ROW_CYCLE_CYC);
                    state_nxt = ST_EXIT_NOP;
                end
            end
            ST_EXIT_NOP:
            begin
                cs_n_nxt = 1'b0;
                if (nopCnt_r != 2'h0)
                    nopCnt_nxt = nopCnt_r - 2'h1;
                if (nopCnt_r <= 2'h1 && !tw.busy)
                begin
                    refDue_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            ST_POWER:
            begin
                if (opWake)
                begin
                    cke_nxt = 1'b1;
                    cs_n_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
            ST_SUSPEND:
            begin
                if (opWake)
                begin
                    cke_nxt = 1'b1;
                    state_nxt = ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
        // Interval expiry last, so a new debt beats a clear in the same cycle
        if (refCnt_r >= 16'(REFRESH_INTERVAL_CYC - 1))
        begin
            refCnt_nxt = 16'h0;
            refDue_nxt = 1'b1;
        end
        ready_nxt = (state_nxt == ST_RUN) && !tw.load && !(tw.busy);
    end

    // Register all state and pins
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_r <= ST_RUN;
            cke_r <= 1'b1;
            cs_n_r <= 1'b1;
            code_r <= `CODE_NOP;
            bank_r <= 2'h0;
            addr_r <= 11'h0;
            mask_r <= 4'hf;
            selfCnt_r <= 16'h0;
            nopCnt_r <= 2'h0;
            refCnt_r <= 16'h0;
            refDue_r <= 1'b0;
            inBurst_r <= 1'b0;
            ready_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cke_r <= cke_nxt;
            cs_n_r <= cs_n_nxt;
            code_r <= code_nxt;
            bank_r <= bank_nxt;
            addr_r <= addr_nxt;
            mask_r <= mask_nxt;
            selfCnt_r <= selfCnt_nxt;
            nopCnt_r <= nopCnt_nxt;
            refCnt_r <= refCnt_nxt;
            refDue_r <= refDue_nxt;
            inBurst_r <= inBurst_nxt;
            ready_r <= ready_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign clkEnable = cke_r;
    assign chipSelect_n = cs_n_r;
    assign rowStrobe_n = code_r[2];
    assign colStrobe_n = code_r[1];
    assign writeStrobe_n = code_r[0];
    assign bank_select = bank_r;
    assign addr = addr_r;
    assign byteMask = mask_r;
    assign opReady = ready_r;
    assign refreshDue = refDue_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    self_hold_a: assert property (@(posedge core_clk) disable iff (srst)
        $fell(cke_r) && code_r == `CODE_REFRESH && !cs_n_r |-> !cke_r [*2])
        else $error("self refresh left too early");
    exit_nop_a: assert property (@(posedge core_clk) disable iff (srst)
        $rose(cke_r) && $past(state_r) == ST_SELF |-> code_r == `CODE_NOP ##1 code_r == `CODE_NOP)
        else $error("command during self refresh exit");
    inhibit_a: assert property (@(posedge core_clk) disable iff (srst)
        cs_n_r |-> code_r == `CODE_NOP)
        else $error("strobes active with chip select high");
    precharge_wait_a: assert property (@(posedge core_clk) disable iff (srst)
        !cs_n_r && code_r == `CODE_PRECHARGE |-> !opReady)
        else $error("ready right after precharge");
    refresh_wait_a: assert property (@(posedge core_clk) disable iff (srst)
        !cs_n_r && code_r == `CODE_REFRESH && cke_r |=> cs_n_r || code_r == `CODE_NOP)
        else $error("command inside refresh cycle");
    power_entry_a: assert property (@(posedge core_clk) disable iff (srst)
        $fell(cke_r) && state_r == ST_POWER |-> code_r == `CODE_NOP)
        else $error("power down entered with a command");
    write_fields_a: assert property (@(posedge core_clk) disable iff (srst)
        opValid && opReady && opCode == OP_WRITE |=>
            code_r == `CODE_WRITE && addr_r[`PRECHARGE_SELECT_POS] == $past(opAutoPre))
        else $error("write fields wrong");
    mask_write_a: assert property (@(posedge core_clk) disable iff (srst)
        opValid && opReady && opCode == OP_WRITE |=> byteMask == $past(opMask))
        else $error("mask not aligned with write");
    suspend_entry_a: assert property (@(posedge core_clk) disable iff (srst)
        $fell(cke_r) && state_r == ST_SUSPEND |-> inBurst_r)
        else $error("clock suspend entered with no burst");
endmodule : sdram_ctl

// file: testbench/sdram_dev_model.sv
// Behavioural four-bank SDRAM that decodes the controller's command pins
`timescale 1ns/10ps
`include "sdram_ctl_defines.svh"
module sdram_dev_model (
    // Clock
    input wire logic core_clk,
    // Command pins
    input wire logic clkEnable,
    input wire logic chipSelect_n,
    input wire logic rowStrobe_n,
    input wire logic colStrobe_n,
    input wire logic writeStrobe_n,
    input wire logic [1:0] bank_select,
    input wire logic [10:0] addr,
    input wire logic [3:0] byteMask
);
    logic cklPrev = 1'b1; // Clock enable seen at the previous edge
    logic [3:0] rowOpen = 4'h0; // Open row flag per bank
    logic [10:0] modeReg = 11'h000; // Mode register image
    logic selfRef = 1'b0; // Self refresh in progress
    logic clockHeld = 1'b0; // Power-down or suspend in progress
    logic [3:0] lanesStored = 4'h0; // Lanes written by the last write
    logic burstOn = 1'b0; // A read or write burst is running
    logic [2:0] code; // Strobe code of this edge
    assign code = {rowStrobe_n, colStrobe_n, writeStrobe_n};

    // Decode one command per rising edge
    always @(posedge core_clk)
    begin
        cklPrev <= clkEnable;
        if (!cklPrev)
        begin
            // Only clock enable counts while held; its rise leaves any low-power mode
            if (clkEnable)
            begin
                selfRef <= 1'b0;
                clockHeld <= 1'b0;
            end
        end
        else if (chipSelect_n)
        begin
            clockHeld <= !clkEnable;
        end
        else
        begin
            case (code)
                `CODE_ACTIVATE: rowOpen[bank_select] <= 1'b1;
                `CODE_WRITE, `CODE_READ:
                begin
                    if (code == `CODE_WRITE)
                        lanesStored <= ~byteMask;
                    if (addr[`PRECHARGE_SELECT_POS])
                        rowOpen[bank_select] <= 1'b0;
                    burstOn <= 1'b1;
                    clockHeld <= !clkEnable;
                end
                `CODE_TERMINATE: burstOn <= 1'b0;
                `CODE_PRECHARGE:
                begin
                    if (addr[`PRECHARGE_SELECT_POS])
                        rowOpen <= 4'h0;
                    else
                        rowOpen[bank_select] <= 1'b0;
                end
                `CODE_REFRESH: selfRef <= !clkEnable;
                `CODE_MODE_LOAD: modeReg <= addr;
                default: clockHeld <= !clkEnable;
            endcase
        end
    end
endmodule : sdram_dev_model

// file: testbench/sdram_command_and_power_states_tb.sv
// Self-checking bench of the SDRAM command controller
`timescale 1ns/10ps
`include "sdram_ctl_defines.svh"
`define CHK(nm, exp, got) \
    begin checksDone++; if ((got) !== (exp)) begin badCount++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module sdram_command_and_power_states_tb;
    import sdram_ctl_pkg::*;
    typedef struct {op_t op; logic [1:0] bk; logic [10:0] ad; logic ap; logic [3:0] mk;
        logic [2:0] code; logic [10:0] amask; logic [3:0] open;} row_t;
    logic core_clk = 1'b0, srst = 1'b1, opValid = 1'b0, opAutoPre = 1'b0, opWake = 1'b0;
    op_t opCode = OP_ACTIVATE;
    logic [1:0] opBank = 2'h0;
    logic [10:0] opAddr = 11'h000;
    logic [3:0] opMask = 4'hf;
    logic opReady, refreshDue, clkEnable, chipSelect_n, rowStrobe_n, colStrobe_n;
    logic writeStrobe_n;
    logic [1:0] bank_select;
    logic [10:0] addr;
    logic [3:0] byteMask;
    logic [2:0] pinCode;
    int badCount = 0, checksDone = 0, n, nopSeen;
    row_t rows [11];
    assign pinCode = {rowStrobe_n, colStrobe_n, writeStrobe_n};

    always #12.5 core_clk = ~core_clk;

    sdram_ctl dut_u (.core_clk(core_clk), .srst(srst),
        .opValid(opValid), .opCode(opCode), .opBank(opBank), .opAddr(opAddr),
        .opAutoPre(opAutoPre), .opMask(opMask), .opWake(opWake), .opReady(opReady),
        .refreshDue(refreshDue), .clkEnable(clkEnable), .chipSelect_n(chipSelect_n),
        .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
        .writeStrobe_n(writeStrobe_n), .bank_select(bank_select), .addr(addr),
        .byteMask(byteMask));
    sdram_dev_model dev_u (.core_clk(core_clk), .clkEnable(clkEnable),
        .chipSelect_n(chipSelect_n), .rowStrobe_n(rowStrobe_n), .colStrobe_n(colStrobe_n),
        .writeStrobe_n(writeStrobe_n), .bank_select(bank_select), .addr(addr),
        .byteMask(byteMask));

    // Counts and verdict, the single end of the run
    task automatic results();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // Wait for opReady, hand over one order, return where its command shows
    task automatic issue(input op_t op, input logic [1:0] bk, input logic [10:0] ad,
        input logic ap, input logic [3:0] mk);
        int k;
        k = 0;
        // At least one idle clock, so opValid never drops and rises in one step
        do
        begin
            @(negedge core_clk);
            k++;
        end
        while (opReady !== 1'b1 && k < 200);
        `CHK("opReady", 1'b1, opReady)
        {opValid, opCode, opBank, opAddr, opAutoPre, opMask} = {1'b1, op, bk, ad, ap, mk};
        @(negedge core_clk);
        opValid = 1'b0;
    endtask : issue

    // Bounded wait for the clock enable pin to rise
    task automatic wakeUp();
        opWake = 1'b1;
        n = 0;
        while (clkEnable !== 1'b1 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        opWake = 1'b0;
        `CHK("clkEnable up", 1'b1, clkEnable)
    endtask : wakeUp

    // Hang guard, well beyond the expected run length
    initial
    begin
        #(25 * 20000);
        badCount++;
        results();
    end

    // Main sequence
    initial
    begin
        rows = '{
            '{OP_ACTIVATE, 2'h2, 11'h7ff, 0, 4'hf, `CODE_ACTIVATE, 11'h7ff, 4'h4},
            '{OP_WRITE, 2'h2, 11'h0a5, 0, 4'h5, `CODE_WRITE, 11'h4ff, 4'h4},
            '{OP_READ, 2'h2, 11'h03c, 1, 4'ha, `CODE_READ, 11'h4ff, 4'h0},
            '{OP_ACTIVATE, 2'h1, 11'h123, 0, 4'hf, `CODE_ACTIVATE, 11'h7ff, 4'h2},
            '{OP_TERMINATE, 2'h0, 11'h000, 0, 4'hf, `CODE_TERMINATE, 11'h000, 4'h2},
            '{OP_PRECHARGE, 2'h1, 11'h000, 0, 4'hf, `CODE_PRECHARGE, 11'h400, 4'h0},
            '{OP_ACTIVATE, 2'h0, 11'h001, 0, 4'hf, `CODE_ACTIVATE, 11'h7ff, 4'h1},
            '{OP_ACTIVATE, 2'h3, 11'h400, 0, 4'hf, `CODE_ACTIVATE, 11'h7ff, 4'h9},
            '{OP_PRECHARGE_ALL, 2'h0, 11'h400, 0, 4'hf, `CODE_PRECHARGE, 11'h400, 4'h0},
            '{OP_REFRESH, 2'h0, 11'h000, 0, 4'hf, `CODE_REFRESH, 11'h000, 4'h0},
            '{OP_MODE_LOAD, 2'h0, 11'h033, 0, 4'hf, `CODE_MODE_LOAD, 11'h7ff, 4'h0}};
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        // Table of ordinary orders
        foreach (rows[i])
        begin
            issue(rows[i].op, rows[i].bk, rows[i].ad, rows[i].ap, rows[i].mk);
            `CHK("select", 1'b0, chipSelect_n)
            `CHK("code", rows[i].code, pinCode)
            `CHK("addr", rows[i].amask & (rows[i].ad | (rows[i].ap << 10)),
                rows[i].amask & addr)
            if (rows[i].amask == 11'h4ff)
            begin
                `CHK("mask", rows[i].mk, byteMask)
                `CHK("bank", rows[i].bk, bank_select)
            end
            @(negedge core_clk);
            `CHK("inhibit", 1'b1, chipSelect_n)
            `CHK("rows", rows[i].open, dev_u.rowOpen)
            if (rows[i].code == `CODE_WRITE)
            begin
                `CHK("lanes", ~rows[i].mk, dev_u.lanesStored)
            end
            if (rows[i].code == `CODE_TERMINATE)
            begin
                `CHK("burst", 1'b0, dev_u.burstOn)
            end
        end
        `CHK("mode", 11'h033, dev_u.modeReg)
        `CHK("no refresh owed", 1'b0, refreshDue)
        $display("test command table done");
        // Write then clock suspend
        issue(OP_ACTIVATE, 2'h0, 11'h010, 1'b0, 4'hf);
        issue(OP_WRITE, 2'h0, 11'h001, 1'b0, 4'h0);
        issue(OP_SUSPEND, 2'h0, 11'h000, 1'b0, 4'hf);
        repeat (3) @(negedge core_clk);
        `CHK("suspend", 1'b0, clkEnable)
        `CHK("suspend state", 1'b1, dev_u.clockHeld)
        wakeUp();
        issue(OP_PRECHARGE_ALL, 2'h0, 11'h000, 1'b0, 4'hf);
        // No burst left, so a suspend order must leave the clock enabled
        issue(OP_SUSPEND, 2'h0, 11'h000, 1'b0, 4'hf);
        `CHK("no burst suspend", 1'b1, clkEnable)
        $display("test clock suspend done");
        // Power-down entry and exit
        issue(OP_POWER_DOWN, 2'h0, 11'h000, 1'b0, 4'hf);
        repeat (5) @(negedge core_clk);
        `CHK("pd cke", 1'b0, clkEnable)
        `CHK("pd state", 1'b1, dev_u.clockHeld)
        wakeUp();
        `CHK("pd exit", 1'b1, chipSelect_n || pinCode == `CODE_NOP)
        $display("test power down done");
        // Self refresh entry, dwell, exit
        issue(OP_SELF_REFRESH, 2'h0, 11'h000, 1'b0, 4'hf);
        `CHK("sr code", `CODE_REFRESH, pinCode)
        `CHK("sr cke", 1'b0, clkEnable)
        repeat (`ROW_ACTIVE_CYC + 6) @(negedge core_clk);
        `CHK("sr hold", 1'b0, clkEnable)
        `CHK("sr state", 1'b1, dev_u.selfRef)
        wakeUp();
        // Count no-op clocks with chip select low until orders are taken again
        n = 0;
        nopSeen = 0;
        while (opReady !== 1'b1 && n < 100)
        begin
            if (chipSelect_n === 1'b0 && pinCode === `CODE_NOP)
                nopSeen++;
            @(negedge core_clk);
            n++;
        end
        `CHK("exit ready", 1'b1, opReady)
        `CHK("exit nops", 1'b1, nopSeen >= `EXIT_NOP_CYC)
        `CHK("refresh owed", 1'b1, refreshDue)
        $display("test self refresh done");
        // Second reset mid-run
        srst = 1'b1;
        repeat (20) @(negedge core_clk);
        `CHK("rst cke", 1'b1, clkEnable)
        `CHK("rst cs", 1'b1, chipSelect_n)
        `CHK("rst mask", 4'hf, byteMask)
        `CHK("rst ready", 1'b0, opReady)
        srst = 1'b0;
        repeat (2) @(negedge core_clk);
        `CHK("ready after", 1'b1, opReady)
        // Refresh falls due once per interval counted from reset
        repeat (`REFRESH_INTERVAL_CYC - 3) @(negedge core_clk);
        `CHK("refresh early", 1'b0, refreshDue)
        @(negedge core_clk);
        `CHK("refresh due", 1'b1, refreshDue)
        $display("test reset done");
        results();
    end
endmodule : sdram_command_and_power_states_tb
